/* rtl/chg_boost_pkg.sv */
// Functional notes
// - Charge, configure or high impedance when selecting charge
// - Boost without fault; any fault goes configure
// - Impedance request with idle OTG forces high impedance
// - 32-second mode boosts on OTG or select bit
// - Boost starts safety timer; kick restarts, self-clears
// - Timer expiry stops boost, pulses, sets fault
// - VBUS overvoltage stops boost, clears select, faults
// - Boost restarts only on reselect or OTG
// - Overload over 30 ms stops boost, faults
// - Overload fault holds boost off until cleared
// - Battery out of range stops boost, faults
// - Boost resumes after battery fault on reselect
// - Status pin open while boosting; one 128-us fault pulse
// - Switching off below 75 mA, on at mid-rail dip
// - Crude timer runs in high impedance at low battery
// - Crude expiry enters 32-minute mode, stops crude timer
// - 32-minute mode with VBUS under UVLO means high impedance
// - Status pin low while charging with indicator enabled
// - Parameter reset restores defaults, bit self-clears
`default_nettype none
package chg_boost_pkg;

    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned TICK_NS = 1000;
    localparam int unsigned TICK_DIV = TICK_NS / CLK_PERIOD_NS;
    localparam logic [7:0] DIV_LAST = 8'(TICK_DIV - 1);
    localparam int unsigned FAULT_PULSE_US = 128;
    localparam int unsigned OVERLOAD_MS = 30;
    localparam int unsigned SAFETY_S = 32;
    localparam int unsigned PULSE_TICKS = FAULT_PULSE_US * 1000 / TICK_NS;
    localparam int unsigned OVERLOAD_TICKS =
        OVERLOAD_MS * 1000000 / TICK_NS + 1;
    // Divide first so the product stays inside 32 bits
    localparam int unsigned SAFETY_TICKS = SAFETY_S * (1000000000 / TICK_NS);

    // Register byte offsets
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] FAULT_ADDR = 8'h08;
    localparam logic [7:0] PARAM_ADDR = 8'h0C;

    // Control fields
    localparam int CT_OPA = 0;
    localparam int CT_HZ = 1;
    localparam int CT_KICK = 2;
    localparam int CT_ENSTAT = 3;
    localparam int CT_PRST = 4;
    localparam logic EN_STAT_RESET = 1'b1;

    // Status fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_LONG = 2;
    localparam int ST_PULSE = 3;
    localparam int ST_SWITCH = 4;

    // Fault fields
    localparam int FAULT_W = 4;
    localparam int FL_TMR = 0;
    localparam int FL_VOVP = 1;
    localparam int FL_OVL = 2;
    localparam int FL_BAT = 3;

    // Charge parameter block
    localparam int PARAM_W = 8;
    localparam logic [PARAM_W-1:0] PARAM_DEFAULT = 8'h3C;

    // Mode codes seen by software
    localparam logic [1:0] MODE_CODE_HIZ = 2'h0;
    localparam logic [1:0] MODE_CODE_CHARGE = 2'h1;
    localparam logic [1:0] MODE_CODE_CFG = 2'h2;
    localparam logic [1:0] MODE_CODE_BOOST = 2'h3;

    typedef enum logic [1:0] {
        MODE_HIZ,
        MODE_CHARGE,
        MODE_CHG_CFG,
        MODE_BOOST
    } mode_type;

    // Comparator and pin flags, all asynchronous to clk
    typedef struct packed {
        logic otg_active;
        logic charge_fault;
        logic mid_rail_low;
        logic ind_current_low;
        logic bat_below_lowv;
        logic bat_below_min;
        logic bat_ovp;
        logic overload;
        logic vbus_ovp;
        logic vbus_below_uvlo;
    } cmp_type;

endpackage
`default_nettype wire

/* rtl/timeout_timer.sv */
`default_nettype none
module timeout_timer #(
    parameter int unsigned LIMIT = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic run,
    input wire logic restart,
    output logic expired
);
    localparam logic [31:0] LAST = 32'(LIMIT - 1);
    logic [31:0] count_reg;

    // Tick counter, cleared when idle or restarted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 32'h0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (!run || restart) begin
                count_reg <= 32'h0;
            end else if (tick) begin
                if (count_reg == LAST) begin
                    count_reg <= 32'h0;
                    expired <= 1'b1;
                end else begin
                    count_reg <= count_reg + 32'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/charger_boost_mode_supervisor.sv */
`default_nettype none
module charger_boost_mode_supervisor
    import chg_boost_pkg::*;
#(
    parameter int unsigned PULSE_LEN = PULSE_TICKS,
    parameter int unsigned OVERLOAD_LEN = OVERLOAD_TICKS,
    parameter int unsigned SAFETY_LEN = SAFETY_TICKS,
    parameter int unsigned CRUDE_LEN = SAFETY_TICKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cmp_type cmp_pins,
    output logic boost_on,
    output logic charge_on,
    output logic hiz_on,
    output logic boost_switch_en,
    output logic stat_out,
    output logic stat_oe,
    output logic [PARAM_W-1:0] charge_params
);
    localparam int CMP_W = $bits(cmp_type);

    logic rst_meta_reg;
    logic rst_n_reg;
    logic [CMP_W-1:0] cmp_meta_reg;
    logic [CMP_W-1:0] cmp_sync_reg;
    cmp_type cmp;
    logic [7:0] div_reg;
    logic tick;
    logic setup;
    logic wr_en;
    logic hit;
    logic wr_ctrl;
    logic wr_fault;
    logic wr_param;
    logic opa_reg;
    logic hz_reg;
    logic kick_reg;
    logic en_stat_reg;
    logic prst_reg;
    logic [PARAM_W-1:0] params_reg;
    logic [FAULT_W-1:0] fault_reg;
    logic [FAULT_W-1:0] fault_set;
    logic fault_evt;
    logic long_mode_reg;
    mode_type mode_reg;
    mode_type mode_next;
    logic boost_act;
    logic boost_req;
    logic boost_block;
    logic pulse_reg;
    logic switch_reg;
    logic stat_oe_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_word;
    logic [1:0] mode_code;
    logic safety_done;
    logic ovl_done;
    logic pulse_done;
    logic crude_done;
    logic crude_run;

    // Reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // Two-stage synchroniser per flag
    generate
        for (genvar i = 0; i < CMP_W; i++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    cmp_meta_reg[i] <= 1'b0;
                    cmp_sync_reg[i] <= 1'b0;
                end else begin
                    cmp_meta_reg[i] <= cmp_pins[i];
                    cmp_sync_reg[i] <= cmp_meta_reg[i];
                end
            end
        end
    endgenerate
    assign cmp = cmp_type'(cmp_sync_reg);

    // Prescaler giving one tick per microsecond
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            div_reg <= 8'h00;
        end else if (div_reg == DIV_LAST) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign tick = (div_reg == DIV_LAST);

    // APB decode; zero wait states
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign hit = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR) ||
                 (paddr == FAULT_ADDR) || (paddr == PARAM_ADDR);
    assign wr_ctrl = wr_en & (paddr == CTRL_ADDR);
    assign wr_fault = wr_en & (paddr == FAULT_ADDR);
    assign wr_param = wr_en & (paddr == PARAM_ADDR);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_reg;

    assign boost_act = (mode_reg == MODE_BOOST);
    assign boost_req = (opa_reg | cmp.otg_active) & ~long_mode_reg;

    // Boost fault sources
    always_comb begin
        fault_set = '0;
        fault_set[FL_TMR] = safety_done;
        fault_set[FL_VOVP] = boost_act & cmp.vbus_ovp;
        fault_set[FL_OVL] = ovl_done;
        fault_set[FL_BAT] = boost_act &
            (cmp.bat_ovp | cmp.bat_below_min);
    end
    assign fault_evt = |fault_set;

    // Boost held off by latched or present faults
    assign boost_block = fault_reg[FL_TMR] | fault_reg[FL_OVL] |
        fault_evt | cmp.vbus_ovp | cmp.bat_ovp | cmp.bat_below_min;

    // Mode selection
    always_comb begin
        if ((hz_reg && !cmp.otg_active) ||
            (long_mode_reg && cmp.vbus_below_uvlo)) begin
            mode_next = MODE_HIZ;
        end else if (boost_act && fault_evt) begin
            mode_next = MODE_CHG_CFG;
        end else if (boost_req) begin
            mode_next = boost_block ? MODE_CHG_CFG : MODE_BOOST;
        end else if (cmp.vbus_below_uvlo) begin
            mode_next = MODE_HIZ;
        end else if (cmp.charge_fault) begin
            mode_next = MODE_CHG_CFG;
        end else begin
            mode_next = MODE_CHARGE;
        end
    end

    // Mode register and registered mode outputs
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mode_reg <= MODE_HIZ;
            boost_on <= 1'b0;
            charge_on <= 1'b0;
            hiz_on <= 1'b1;
        end else begin
            mode_reg <= mode_next;
            boost_on <= (mode_next == MODE_BOOST);
            charge_on <= (mode_next == MODE_CHARGE);
            hiz_on <= (mode_next == MODE_HIZ);
        end
    end

    // Control bits; hardware fault clear of select wins
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            opa_reg <= 1'b0;
            hz_reg <= 1'b0;
            en_stat_reg <= EN_STAT_RESET;
        end else begin
            if (wr_ctrl) begin
                opa_reg <= pwdata[CT_OPA];
                hz_reg <= pwdata[CT_HZ];
                en_stat_reg <= pwdata[CT_ENSTAT];
            end
            if (fault_set[FL_VOVP] | fault_set[FL_OVL] |
                fault_set[FL_BAT]) begin
                opa_reg <= 1'b0;
            end
        end
    end

    // Self-clearing timer kick
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            kick_reg <= 1'b0;
        end else begin
            kick_reg <= wr_ctrl & pwdata[CT_KICK];
        end
    end

    // Parameter reset and parameter block
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            prst_reg <= 1'b0;
            params_reg <= PARAM_DEFAULT;
        end else begin
            prst_reg <= wr_ctrl & pwdata[CT_PRST];
            if (prst_reg) begin
                params_reg <= PARAM_DEFAULT;
            end else if (wr_param) begin
                params_reg <= pwdata[PARAM_W-1:0];
            end
        end
    end
    assign charge_params = params_reg;

    // Sticky fault bits, write one to clear, set wins
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            fault_reg <= '0;
        end else begin
            fault_reg <= (fault_reg &
                ~(wr_fault ? pwdata[FAULT_W-1:0] : '0)) | fault_set;
        end
    end

    // Boost safety timer, restarted by kick
    timeout_timer #(.LIMIT(SAFETY_LEN)) u_safety (
        .clk(clk),
        .rst_n(rst_n_reg),
        .tick(tick),
        .run(boost_act),
        .restart(kick_reg),
        .expired(safety_done)
    );

    // Overload persistence timer
    timeout_timer #(.LIMIT(OVERLOAD_LEN)) u_overload (
        .clk(clk),
        .rst_n(rst_n_reg),
        .tick(tick),
        .run(boost_act & cmp.overload),
        .restart(1'b0),
        .expired(ovl_done)
    );

    // Fault pulse width timer
    timeout_timer #(.LIMIT(PULSE_LEN)) u_pulse (
        .clk(clk),
        .rst_n(rst_n_reg),
        .tick(tick),
        .run(pulse_reg),
        .restart(1'b0),
        .expired(pulse_done)
    );

    // Crude timer in high impedance at low battery
    assign crude_run = (mode_reg == MODE_HIZ) & cmp.bat_below_lowv &
        ~long_mode_reg;
    timeout_timer #(.LIMIT(CRUDE_LEN)) u_crude (
        .clk(clk),
        .rst_n(rst_n_reg),
        .tick(tick),
        .run(crude_run),
        .restart(1'b0),
        .expired(crude_done)
    );

    // Timer mode: crude expiry enters 32-minute mode
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            long_mode_reg <= 1'b0;
        end else if (crude_done) begin
            long_mode_reg <= 1'b1;
        end else if (wr_ctrl) begin
            long_mode_reg <= 1'b0;
        end
    end

    // Single fault pulse; faults during a pulse join it
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pulse_reg <= 1'b0;
        end else if (fault_evt && !pulse_reg) begin
            pulse_reg <= 1'b1;
        end else if (pulse_done) begin
            pulse_reg <= 1'b0;
        end
    end

    // Status pin drive, open drain low only
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            stat_oe_reg <= 1'b0;
        end else begin
            stat_oe_reg <= pulse_reg |
                ((mode_reg == MODE_CHARGE) & en_stat_reg);
        end
    end
    assign stat_oe = stat_oe_reg;
    assign stat_out = 1'b0;

    // Light-load switching control
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            switch_reg <= 1'b1;
        end else if (!boost_act) begin
            switch_reg <= 1'b1;
        end else if (!switch_reg && cmp.mid_rail_low) begin
            switch_reg <= 1'b1;
        end else if (switch_reg && cmp.ind_current_low) begin
            switch_reg <= 1'b0;
        end
    end
    assign boost_switch_en = switch_reg & boost_on;

    // Mode code for status
    always_comb begin
        unique case (mode_reg)
            MODE_HIZ: mode_code = MODE_CODE_HIZ;
            MODE_CHARGE: mode_code = MODE_CODE_CHARGE;
            MODE_CHG_CFG: mode_code = MODE_CODE_CFG;
            MODE_BOOST: mode_code = MODE_CODE_BOOST;
        endcase
    end

    // Read word selection
    always_comb begin
        rd_word = 32'h0;
        unique case (paddr)
            CTRL_ADDR: begin
                rd_word[CT_OPA] = opa_reg;
                rd_word[CT_HZ] = hz_reg;
                rd_word[CT_KICK] = kick_reg;
                rd_word[CT_ENSTAT] = en_stat_reg;
                rd_word[CT_PRST] = prst_reg;
            end
            STATUS_ADDR: begin
                rd_word[ST_MODE_LSB +: 2] = mode_code;
                rd_word[ST_LONG] = long_mode_reg;
                rd_word[ST_PULSE] = pulse_reg;
                rd_word[ST_SWITCH] = switch_reg;
            end
            FAULT_ADDR: rd_word[FAULT_W-1:0] = fault_reg;
            PARAM_ADDR: rd_word[PARAM_W-1:0] = params_reg;
            default: rd_word = 32'h0;
        endcase
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            prdata_reg <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata_reg <= rd_word;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n_reg);

    hiz_request_a: assert property (
        hz_reg && !cmp.otg_active |=> mode_reg == MODE_HIZ)
        else $error("impedance request did not give high impedance");

    charge_uvlo_a: assert property (
        !opa_reg && !hz_reg && !cmp.otg_active && cmp.vbus_below_uvlo
        |=> mode_reg == MODE_HIZ)
        else $error("charge side with low VBUS not in high impedance");

    boost_cause_a: assert property (
        $rose(boost_on) |-> $past(boost_req) && !$past(long_mode_reg))
        else $error("boost entered without a request");

    boost_fault_a: assert property (
        boost_act && fault_evt && !hz_reg |=> mode_reg == MODE_CHG_CFG)
        else $error("boost fault did not go to configure");

    kick_clear_a: assert property (
        wr_ctrl && pwdata[CT_KICK] |=> kick_reg ##1 !kick_reg)
        else $error("timer kick did not self clear");

    timer_expiry_a: assert property (
        safety_done |=> fault_reg[FL_TMR] && mode_reg != MODE_BOOST)
        else $error("safety expiry did not stop boost");

    vbus_ovp_a: assert property (
        boost_act && cmp.vbus_ovp |=> !opa_reg && fault_reg[FL_VOVP]
        ##1 stat_oe_reg)
        else $error("VBUS overvoltage not handled");

    overload_hold_a: assert property (
        fault_reg[FL_OVL] |-> mode_reg != MODE_BOOST)
        else $error("boost running with overload fault latched");

    overload_time_a: assert property (
        $rose(fault_reg[FL_OVL]) |-> $past(cmp.overload, 2))
        else $error("overload fault without persisting overload");

    single_pulse_a: assert property (
        pulse_reg && !pulse_done |=> pulse_reg)
        else $error("fault pulse cut short");

    switch_off_a: assert property (
        boost_act && switch_reg && cmp.ind_current_low && boost_on
        |=> !boost_switch_en)
        else $error("switching not stopped at low inductor current");

    long_uvlo_a: assert property (
        long_mode_reg && cmp.vbus_below_uvlo |=> hiz_on)
        else $error("32-minute mode with low VBUS not high impedance");

    param_reset_a: assert property (
        wr_ctrl && pwdata[CT_PRST] |=> ##1
        params_reg == PARAM_DEFAULT && !prst_reg)
        else $error("parameter reset not applied");

endmodule
`default_nettype wire

/* verification/analog_front_model.sv */
`default_nettype none
module analog_front_model
    import chg_boost_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire cmp_type flags_req,
    output var cmp_type flags_pin,
    input wire logic stat_out,
    input wire logic stat_oe,
    output logic stat_level
);
    timeunit 1ns;
    timeprecision 1ns;
    cmp_type lag_reg;
    // Slow comparators settle one clock late
    always_ff @(posedge clk) begin
        lag_reg <= flags_req;
    end
    assign flags_pin = slow ? lag_reg : flags_req;
    // Open-drain status line with pull-up
    assign stat_level = stat_oe ? stat_out : 1'b1;
endmodule
`default_nettype wire

/* verification/charger_boost_mode_supervisor_tb.sv */
`default_nettype none
module charger_boost_mode_supervisor_tb
    import chg_boost_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    cmp_type flags_req, flags_pin;
    logic boost_on, charge_on, hiz_on, boost_switch_en;
    logic stat_out, stat_oe, stat_level, slow;
    logic [PARAM_W-1:0] charge_params;
    int bad_count, checked, waited;

    // Short counts: 4, 6, 40, 40 ticks of 20 clocks
    charger_boost_mode_supervisor #(.PULSE_LEN(4), .OVERLOAD_LEN(6),
        .SAFETY_LEN(40), .CRUDE_LEN(40)) i_charger_boost_mode_supervisor (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_pins(flags_pin),
        .boost_on(boost_on), .charge_on(charge_on), .hiz_on(hiz_on),
        .boost_switch_en(boost_switch_en), .stat_out(stat_out),
        .stat_oe(stat_oe), .charge_params(charge_params));

    analog_front_model i_analog_front_model (.clk(clk), .slow(slow),
        .flags_req(flags_req), .flags_pin(flags_pin), .stat_out(stat_out),
        .stat_oe(stat_oe), .stat_level(stat_level));

    // Verdict and end of run
    task automatic test_done;
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic fail_wait(input string nm);
        bad_count++;
        $display("[ERR] %s expected done seen timeout", nm);
        test_done();
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge clk);
        if (pready !== 1'b1) fail_wait("pready");
        rdat = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_boost(input logic v, input int lim);
        for (waited = 0; boost_on !== v; waited++) begin
            if (waited == lim) fail_wait("boost_on");
            @(posedge clk);
        end
    endtask

    // Measures one low pulse, then looks for any further pulse
    task automatic pulse_check;
        int n, w, p;
        logic prev;
        for (n = 0; stat_level !== 1'b0; n++) begin
            if (n == 40) fail_wait("stat_level");
            @(posedge clk);
        end
        w = 0;
        p = 0;
        prev = 1'b0;
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            if (prev === 1'b1 && stat_level === 1'b0) p++;
            if (stat_level === 1'b0) w++;
            prev = stat_level;
        end
        check("pulse_len", 32'(w >= 55 && w <= 105), 32'h1);
        check("extra_pulses", 32'(p), 32'h0);
    endtask

    task automatic t_reset;
        rd(PARAM_ADDR);
        check("param", rdat, 32'(PARAM_DEFAULT));
        rd(STATUS_ADDR);
        check("mode", 32'(rdat[1:0]), 32'(MODE_CODE_CHARGE));
        check("stat_chg", 32'(stat_level), 32'h0);
        rd(CTRL_ADDR);
        check("ctrl", rdat, 32'h8);
        rd(8'h10);
        check("unmapped_err", 32'(last_err), 32'h1);
        check("unmapped_data", rdat, 32'h0);
        wr(CTRL_ADDR, 32'h0);
        idle(4);
        check("stat_off", 32'(stat_level), 32'h1);
    endtask

    task automatic t_modes;
        flags_req.charge_fault <= 1'b1;
        idle(8);
        rd(STATUS_ADDR);
        check("cfg_mode", 32'(rdat[1:0]), 32'(MODE_CODE_CFG));
        flags_req.vbus_below_uvlo <= 1'b1;
        idle(8);
        check("uvlo_hiz", 32'(hiz_on), 32'h1);
        flags_req <= '0;
        idle(8);
        check("charge", 32'(charge_on), 32'h1);
        wr(CTRL_ADDR, 32'h3);
        idle(8);
        check("req_hiz", 32'({hiz_on, boost_on}), 32'h2);
        flags_req.otg_active <= 1'b1;
        idle(8);
        check("otg_boost", 32'(boost_on), 32'h1);
        flags_req <= '0;
        wr(CTRL_ADDR, 32'h0);
        idle(8);
    endtask

    task automatic t_param;
        wr(PARAM_ADDR, 32'h55);
        rd(PARAM_ADDR);
        check("param_wr", rdat, 32'h55);
        check("param_out", 32'(charge_params), 32'h55);
        wr(CTRL_ADDR, 32'h10);
        idle(3);
        rd(PARAM_ADDR);
        check("param_rst", rdat, 32'(PARAM_DEFAULT));
        rd(CTRL_ADDR);
        check("prst_clear", rdat, 32'h0);
    endtask

    task automatic t_safety;
        wr(CTRL_ADDR, 32'h1);
        wait_boost(1'b1, 40);
        check("stat_boost", 32'(stat_level), 32'h1);
        flags_req.ind_current_low <= 1'b1;
        idle(8);
        check("pfm_off", 32'(boost_switch_en), 32'h0);
        flags_req.ind_current_low <= 1'b0;
        flags_req.mid_rail_low <= 1'b1;
        idle(8);
        check("pfm_on", 32'(boost_switch_en), 32'h1);
        flags_req.mid_rail_low <= 1'b0;
        repeat (3) begin
            idle(600);
            wr(CTRL_ADDR, 32'h5);
            rd(CTRL_ADDR);
            check("kick_clear", 32'(rdat[2]), 32'h0);
            check("kept", 32'(boost_on), 32'h1);
        end
        wait_boost(1'b0, 1000);
        check("expiry", 32'(waited >= 700), 32'h1);
        pulse_check();
        rd(FAULT_ADDR);
        check("tmr_fault", rdat, 32'h1);
        wr(FAULT_ADDR, 32'h1);
        rd(FAULT_ADDR);
        check("tmr_clear", rdat, 32'h0);
        wait_boost(1'b1, 40);
    endtask

    task automatic t_vbus;
        flags_req.vbus_ovp <= 1'b1;
        flags_req.bat_ovp <= 1'b1;
        wait_boost(1'b0, 20);
        pulse_check();
        rd(FAULT_ADDR);
        check("both_bits", rdat, 32'hA);
        rd(CTRL_ADDR);
        check("opa_forced", rdat, 32'h0);
        flags_req <= '0;
        idle(20);
        check("no_restart", 32'(boost_on), 32'h0);
        wr(FAULT_ADDR, 32'hF);
        wr(CTRL_ADDR, 32'h1);
        wait_boost(1'b1, 40);
    endtask

    task automatic t_overload;
        slow <= 1'b1;
        flags_req.overload <= 1'b1;
        idle(60);
        flags_req.overload <= 1'b0;
        idle(20);
        check("short_ovl", 32'(boost_on), 32'h1);
        flags_req.overload <= 1'b1;
        wait_boost(1'b0, 400);
        check("ovl_time", 32'(waited >= 100), 32'h1);
        flags_req.overload <= 1'b0;
        pulse_check();
        rd(FAULT_ADDR);
        check("ovl_bit", rdat, 32'h4);
        wr(CTRL_ADDR, 32'h1);
        idle(40);
        check("ovl_hold", 32'(boost_on), 32'h0);
        wr(FAULT_ADDR, 32'h4);
        wr(CTRL_ADDR, 32'h1);
        wait_boost(1'b1, 40);
        flags_req.bat_below_min <= 1'b1;
        wait_boost(1'b0, 20);
        pulse_check();
        rd(FAULT_ADDR);
        check("bat_bit", rdat, 32'h8);
        flags_req.bat_below_min <= 1'b0;
        idle(10);
        wr(FAULT_ADDR, 32'h8);
        wr(CTRL_ADDR, 32'h1);
        wait_boost(1'b1, 40);
        slow <= 1'b0;
    endtask

    task automatic t_crude;
        wr(CTRL_ADDR, 32'h2);
        idle(1000);
        rd(STATUS_ADDR);
        check("no_crude", 32'(rdat[2]), 32'h0);
        flags_req.bat_below_lowv <= 1'b1;
        idle(900);
        rd(STATUS_ADDR);
        check("long_mode", 32'(rdat[2]), 32'h1);
        flags_req.otg_active <= 1'b1;
        idle(8);
        check("long_no_boost", 32'(boost_on), 32'h0);
        flags_req.vbus_below_uvlo <= 1'b1;
        idle(8);
        check("long_hiz", 32'(hiz_on), 32'h1);
    endtask

    // Clock at 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Reset, then the scenarios in turn
    initial begin
        bad_count = 0;
        checked = 0;
        resetn = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        flags_req = '0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        idle(3);
        t_reset();
        t_modes();
        t_param();
        t_safety();
        t_vbus();
        t_overload();
        t_crude();
        test_done();
    end
endmodule
`default_nettype wire
